// ==== rtl/spgc_top.sv ====
// sector pattern generator and checker with an apb register slave
`timescale 1ns/1ps
`include "spgc_consts.svh"

// Function
// - a one-cycle write start pulse sets write-transfer-active.
// - while active and outbound fifo not almost full, push one word per cycle.
// - almost full high drops the outbound write strobe until it clears.
// - word counter counts strobes; reaching end size ends the write transfer.
// - end size is derived from the transfer length given in sectors.
// - inbound read strobe is the inverse of the inbound fifo empty flag.
// - in read, each read strobe advances the word counter and expected pattern.
// - each sector is 64-bit header in words 0-1, pattern in words 2-127.
// - lba counter loads start address, feeds header, increments after each sector.
// - sector end is word counter at last word with an active strobe.
// - increment pattern joins low lba counter bits with the word counter.
// - decrement pattern is the bitwise inverse of the increment word.
// - lfsr seeded per sector with low lba word, polynomial x^31+x^21+x+1.
// - three-bit pattern select picks one of five patterns.
// - header goes into first two words of every sector, then pattern words.
// - on read the generated word is compared; any mismatch raises fail.
// - 32-bit data path, everything on the single core clock.
// - select codes 000 inc, 001 dec, 010 zeros, 011 ones, 100 lfsr.
// - on the first read failure after a start latch failing byte address, expected and received word.
module spgc_top #(
   parameter int LEN_W = 32
)(
   input  wire logic                i_core_clk,
   input  wire logic                i_rst,
   input  wire logic                i_psel,
   input  wire logic                i_penable,
   input  wire logic                i_pwrite,
   input  wire logic [7:0]          i_paddr,
   input  wire logic [31:0]         i_pwdata,
   output logic                     o_pready,
   output logic                     o_pslverr,
   output logic [31:0]              o_prdata,
   input  wire logic                i_out_afull,
   output spgc_pkg::spgc_out_t      o_out,
   input  wire logic                i_in_empty,
   input  wire logic [31:0]         i_in_data,
   output logic                     o_in_rd,
   output logic                     o_busy,
   output logic                     o_fail
);
   localparam int CW = LEN_W + `SPGC_WIDX_W;

   // ****************************************
   // apb slave
   // ****************************************
   logic                   pready_reg;
   logic                   pslverr_reg;
   logic [31:0]            prdata_reg;
   logic [47:0]            lba_start_reg;
   logic [LEN_W-1:0]       len_reg;
   spgc_pkg::spgc_pat_t    pat_reg;
   logic                   wr_start_reg;
   logic                   rd_start_reg;
   logic                   wr_active_reg;
   logic                   rd_active_reg;
   logic [CW-1:0]          end_size_reg;
   logic [CW-1:0]          word_cnt_reg;
   logic [47:0]            lba_cnt_reg;
   logic [31:0]            lfsr_reg;
   logic                   fail_reg;
   spgc_pkg::spgc_fail_t   fail_rec_reg;
   spgc_pkg::spgc_out_t    out_reg;
   logic                   access;
   logic                   wr_take;
   logic                   mapped;
   logic [31:0]            rd_mux;

   // register hit, used by both the write decode and the read mux
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction : hit

   assign access   = i_psel & i_penable;
   assign wr_take  = access & pready_reg & i_pwrite;
   assign mapped   = (i_paddr <= `SPGC_OFF_WCNT) & (i_paddr[1:0] == 2'h0);
   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_prdata  = prdata_reg;

   // read mux; unmapped offsets read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit(i_paddr, `SPGC_OFF_LBA_LO))  rd_mux = lba_start_reg[31:0];
      if (hit(i_paddr, `SPGC_OFF_LBA_HI))  rd_mux = {16'h0000, lba_start_reg[47:32]};
      if (hit(i_paddr, `SPGC_OFF_LEN))     rd_mux = 32'(len_reg);
      if (hit(i_paddr, `SPGC_OFF_PAT))     rd_mux = {29'h0000_0000, pat_reg};
      if (hit(i_paddr, `SPGC_OFF_STATUS))
         rd_mux = {29'h0000_0000, fail_reg, rd_active_reg, wr_active_reg};
      if (hit(i_paddr, `SPGC_OFF_FAIL_LO)) rd_mux = fail_rec_reg.byte_addr[31:0];
      if (hit(i_paddr, `SPGC_OFF_FAIL_HI)) rd_mux = {7'h00, fail_rec_reg.byte_addr[56:32]};
      if (hit(i_paddr, `SPGC_OFF_EXP))     rd_mux = fail_rec_reg.expected;
      if (hit(i_paddr, `SPGC_OFF_RCV))     rd_mux = fail_rec_reg.received;
      if (hit(i_paddr, `SPGC_OFF_WCNT))    rd_mux = word_cnt_reg[31:0];
   end

   // one wait state so read data comes straight from a flop
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= `SPGC_WORD_RST;
      end
      else
      begin
         pready_reg  <= access & ~pready_reg;
         pslverr_reg <= access & ~pready_reg & ~mapped;
         prdata_reg  <= (access & ~pready_reg & ~i_pwrite) ? rd_mux : `SPGC_WORD_RST;
      end
   end

   // parameter registers and self-clearing command pulses
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         lba_start_reg <= `SPGC_LBA_RST;
         len_reg       <= LEN_W'(`SPGC_LEN_RST);
         pat_reg       <= spgc_pkg::SPGC_PAT_INC;
         wr_start_reg  <= 1'b0;
         rd_start_reg  <= 1'b0;
      end
      else
      begin
         wr_start_reg <= wr_take & hit(i_paddr, `SPGC_OFF_CMD) & i_pwdata[`SPGC_CMD_WR_BIT];
         rd_start_reg <= wr_take & hit(i_paddr, `SPGC_OFF_CMD) & i_pwdata[`SPGC_CMD_RD_BIT];
         if (wr_take & hit(i_paddr, `SPGC_OFF_LBA_LO)) lba_start_reg[31:0]  <= i_pwdata;
         if (wr_take & hit(i_paddr, `SPGC_OFF_LBA_HI)) lba_start_reg[47:32] <= i_pwdata[15:0];
         if (wr_take & hit(i_paddr, `SPGC_OFF_LEN))    len_reg <= i_pwdata[LEN_W-1:0];
         if (wr_take & hit(i_paddr, `SPGC_OFF_PAT))
            pat_reg <= spgc_pkg::spgc_pat_t'(i_pwdata[2:0]);
      end
   end

   // ****************************************
   // transfer control
   // ****************************************
   logic                   busy;
   logic                   wr_go;
   logic                   rd_go;
   logic                   wr_step;
   logic                   rd_step;
   logic                   step;
   logic                   last_step;
   logic                   sector_end;
   logic [6:0]             widx;
   logic [31:0]            gen_word;
   logic [31:0]            inc_word;

   // starts while busy or with zero length are dropped; write wins over read
   assign busy       = wr_active_reg | rd_active_reg;
   assign wr_go      = wr_start_reg & ~busy & (len_reg != '0);
   assign rd_go      = rd_start_reg & ~wr_start_reg & ~busy & (len_reg != '0);
   assign o_in_rd    = ~i_in_empty;
   assign wr_step    = wr_active_reg & ~i_out_afull;
   assign rd_step    = rd_active_reg & o_in_rd;
   assign step       = wr_step | rd_step;
   assign widx       = word_cnt_reg[6:0];
   assign last_step  = step & (word_cnt_reg + CW'(1) == end_size_reg);
   assign sector_end = step & (widx == `SPGC_LAST_WORD);
   assign o_out      = out_reg;
   assign o_busy     = busy;
   assign o_fail     = fail_reg;

   // active flags and end size; the fifo's almost-full slack absorbs the 1-cycle lag
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_active_reg <= 1'b0;
         rd_active_reg <= 1'b0;
         end_size_reg  <= '0;
      end
      else
      begin
         if (wr_go | rd_go)
            end_size_reg <= {len_reg, 7'h00};
         if (wr_go)
            wr_active_reg <= 1'b1;
         else if (wr_step & last_step)
            wr_active_reg <= 1'b0;
         if (rd_go)
            rd_active_reg <= 1'b1;
         else if (rd_step & last_step)
            rd_active_reg <= 1'b0;
      end
   end

   // one lfsr step, x^31 + x^21 + x + 1
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[30] ^ s[20] ^ s[0]};
   endfunction : lfsr_next

   // word, lba and lfsr counters
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         word_cnt_reg <= '0;
         lba_cnt_reg  <= `SPGC_LBA_RST;
         lfsr_reg     <= `SPGC_WORD_RST;
      end
      else if (wr_go | rd_go)
      begin
         word_cnt_reg <= '0;
         lba_cnt_reg  <= lba_start_reg;
         lfsr_reg     <= lba_start_reg[31:0];
      end
      else if (step)
      begin
         word_cnt_reg <= word_cnt_reg + CW'(1);
         if (sector_end)
         begin
            lba_cnt_reg <= lba_cnt_reg + 48'h0000_0000_0001;
            lfsr_reg    <= lba_cnt_reg[31:0] + 32'h0000_0001;
         end
         else if (widx != `SPGC_HDR_WORD0)
            lfsr_reg <= lfsr_next(lfsr_reg);
      end
   end

   // ****************************************
   // pattern engine
   // ****************************************
   assign inc_word = {lba_cnt_reg[24:0], widx};

   // header words first, then the selected pattern; lfsr stalls on a zero seed
   always_comb
   begin
      gen_word = 32'h0000_0000;
      unique case (widx)
         `SPGC_HDR_WORD0: gen_word = lba_cnt_reg[31:0];
         `SPGC_HDR_WORD1: gen_word = {16'h0000, lba_cnt_reg[47:32]};
         default:
         begin
            unique case (pat_reg)
               spgc_pkg::SPGC_PAT_INC:  gen_word = inc_word;
               spgc_pkg::SPGC_PAT_DEC:  gen_word = ~inc_word;
               spgc_pkg::SPGC_PAT_ZERO: gen_word = 32'h0000_0000;
               spgc_pkg::SPGC_PAT_ONE:  gen_word = 32'hFFFF_FFFF;
               spgc_pkg::SPGC_PAT_LFSR: gen_word = lfsr_reg;
               default:                 gen_word = 32'h0000_0000;
            endcase
         end
      endcase
   end

   // outbound word and strobe from flops
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
         out_reg <= '0;
      else
      begin
         out_reg.wr <= wr_step;
         if (wr_step)
            out_reg.data <= gen_word;
      end
   end

   // checker: first mismatch recorded, flag sticky until next start
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         fail_reg     <= 1'b0;
         fail_rec_reg <= '0;
      end
      else if (wr_go | rd_go)
         fail_reg <= 1'b0;
      else if (rd_step & (i_in_data != gen_word))
      begin
         fail_reg <= 1'b1;
         if (!fail_reg)
         begin
            fail_rec_reg.byte_addr <= {lba_cnt_reg, widx, 2'h0};
            fail_rec_reg.expected  <= gen_word;
            fail_rec_reg.received  <= i_in_data;
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   sequence s_wr_stop;
      !wr_active_reg ##1 !out_reg.wr;
   endsequence

   property p_wr_start;
      wr_go |=> wr_active_reg && word_cnt_reg == '0;
   endproperty
   a_wr_start: assert property (p_wr_start) else $error("write start not taken");

   property p_push;
      wr_active_reg && !i_out_afull |=> out_reg.wr && out_reg.data == $past(gen_word);
   endproperty
   a_push: assert property (p_push) else $error("push missing");

   property p_afull;
      i_out_afull |=> !out_reg.wr;
   endproperty
   a_afull: assert property (p_afull) else $error("push during almost full");

   property p_wr_end;
      wr_step && last_step |=> s_wr_stop;
   endproperty
   a_wr_end: assert property (p_wr_end) else $error("write did not stop");

   property p_rd_count;
      rd_step && !last_step |=> word_cnt_reg == $past(word_cnt_reg) + CW'(1) && rd_active_reg;
   endproperty
   a_rd_count: assert property (p_rd_count) else $error("read count wrong");

   property p_lba_inc;
      sector_end |=> lba_cnt_reg == $past(lba_cnt_reg) + 48'h0000_0000_0001;
   endproperty
   a_lba_inc: assert property (p_lba_inc) else $error("lba not advanced");

   property p_header;
      widx == `SPGC_HDR_WORD0 |-> gen_word == lba_cnt_reg[31:0];
   endproperty
   a_header: assert property (p_header) else $error("header word wrong");

   property p_dec;
      pat_reg == spgc_pkg::SPGC_PAT_DEC && widx >= `SPGC_FIRST_DATA
         |-> gen_word == ~{lba_cnt_reg[24:0], widx};
   endproperty
   a_dec: assert property (p_dec) else $error("decrement word wrong");

   property p_mismatch;
      rd_step && i_in_data != gen_word |=> fail_reg;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");

   property p_sticky;
      fail_reg && !(wr_go || rd_go) |=> fail_reg;
   endproperty
   a_sticky: assert property (p_sticky) else $error("fail flag dropped");

   property p_restart;
      rd_go |=> word_cnt_reg == '0 && lba_cnt_reg == $past(lba_start_reg) && !fail_reg;
   endproperty
   a_restart: assert property (p_restart) else $error("counters not reset");
endmodule : spgc_top

// ==== rtl/spgc_consts.svh ====
// register offsets, field positions, reset values and sector geometry of the pattern engine
`ifndef SPGC_CONSTS_SVH
`define SPGC_CONSTS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SPGC_OFF_LBA_LO    8'h00
`define SPGC_OFF_LBA_HI    8'h04
`define SPGC_OFF_LEN       8'h08
`define SPGC_OFF_CMD       8'h0C
`define SPGC_OFF_PAT       8'h10
`define SPGC_OFF_STATUS    8'h14
`define SPGC_OFF_FAIL_LO   8'h18
`define SPGC_OFF_FAIL_HI   8'h1C
`define SPGC_OFF_EXP       8'h20
`define SPGC_OFF_RCV       8'h24
`define SPGC_OFF_WCNT      8'h28
// ****************************************
// field positions
// ****************************************
`define SPGC_CMD_WR_BIT    0
`define SPGC_CMD_RD_BIT    1
`define SPGC_STS_WR_BIT    0
`define SPGC_STS_RD_BIT    1
`define SPGC_STS_FAIL_BIT  2
// ****************************************
// reset values
// ****************************************
`define SPGC_LBA_RST       48'h0000_0000_0000
`define SPGC_LEN_RST       32'h0000_0000
`define SPGC_WORD_RST      32'h0000_0000
// ****************************************
// sector geometry: 128 words, 2 header words
// ****************************************
`define SPGC_WIDX_W        7
`define SPGC_LAST_WORD     7'h7F
`define SPGC_HDR_WORD0     7'h00
`define SPGC_HDR_WORD1     7'h01
`define SPGC_FIRST_DATA    7'h02
`endif

// ==== rtl/spgc_pkg.sv ====
// types shared by the sector pattern generator and checker
package spgc_pkg;
   // pattern select codes
   typedef enum logic [2:0]
   {
      SPGC_PAT_INC  = 3'h0,
      SPGC_PAT_DEC  = 3'h1,
      SPGC_PAT_ZERO = 3'h2,
      SPGC_PAT_ONE  = 3'h3,
      SPGC_PAT_LFSR = 3'h4
   } spgc_pat_t;

   // outbound fifo write port
   typedef struct packed
   {
      logic        wr;
      logic [31:0] data;
   } spgc_out_t;

   // record of the first verification failure
   typedef struct packed
   {
      logic [56:0] byte_addr;
      logic [31:0] expected;
      logic [31:0] received;
   } spgc_fail_t;
endpackage : spgc_pkg

// ==== verification/spgc_fifo_model.sv ====
// fifo partner model: outbound sink with almost full, inbound first-word-fall-through source
`timescale 1ns/1ps
module spgc_fifo_model (
   input  wire logic                i_core_clk,
   input  wire logic                i_rst,
   input  wire spgc_pkg::spgc_out_t i_out,
   input  wire logic                i_drain,
   input  wire logic                i_in_rd,
   input  wire logic                i_slow,
   output logic                     o_afull,
   output logic                     o_ovf,
   output logic                     o_in_empty,
   output logic [31:0]              o_in_data
);
   logic [31:0] out_q[$];
   logic [31:0] in_q[$];
   int          level;
   logic        tog;
   logic [31:0] last;
   // ****************************************
   // outbound side
   // ****************************************
   // afull leaves slots free since the generator stops one cycle late
   assign o_afull = (level >= 5);
   // level tracks words held, eight slots deep
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         level <= 0;
         o_ovf <= 1'b0;
      end
      else
      begin
         level <= level + (i_out.wr ? 1 : 0) - ((i_drain && level > 0) ? 1 : 0);
         o_ovf <= o_ovf | (level > 8);
         if (i_out.wr)
            out_q.push_back(i_out.data);
      end
   end
   // ****************************************
   // inbound side
   // ****************************************
   // an empty fifo shows the inverse of the last word, never a stale copy
   always @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tog = 1'b0;
         o_in_empty <= 1'b1;
         o_in_data <= ~last;
      end
      else
      begin
         tog = ~tog;
         if (!o_in_empty && i_in_rd)
            last = in_q.pop_front();
         if (in_q.size() > 0 && !(i_slow && tog))
         begin
            o_in_empty <= 1'b0;
            o_in_data <= in_q[0];
         end
         else
         begin
            o_in_empty <= 1'b1;
            o_in_data <= ~last;
         end
      end
   end
endmodule : spgc_fifo_model

// ==== verification/spgc_top_bench.sv ====
// self-checking bench of the sector pattern generator and checker
`timescale 1ns/1ps
`include "spgc_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module spgc_top_bench;
   logic                core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, prdata, in_data, q, w;
   logic                afull, in_empty, in_rd, busy, fail, drain, slow, ovf, stall, qerr;
   spgc_pkg::spgc_out_t out_s;
   int                  failures, check_count, cyc;
   spgc_top spgc_top_i (.i_core_clk(core_clk), .i_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_out_afull(afull),
      .o_out(out_s), .i_in_empty(in_empty), .i_in_data(in_data), .o_in_rd(in_rd),
      .o_busy(busy), .o_fail(fail));
   spgc_fifo_model spgc_fifo_model_i (.i_core_clk(core_clk), .i_rst(rst), .i_out(out_s),
      .i_drain(drain), .i_in_rd(in_rd), .i_slow(slow), .o_afull(afull), .o_ovf(ovf),
      .o_in_empty(in_empty), .o_in_data(in_data));
   // ****************************************
   // clock, drain pacing and hang guard
   // ****************************************
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // a stalled sink drains one word in four so afull really toggles
   always @(posedge core_clk)
   begin
      drain <= ~stall | (cyc % 4 == 0);
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         failures++;
         wrap_up();
      end
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] exp_w(logic [47:0] lba, int wi, logic [2:0] p);
      logic [31:0] s = lba[31:0];
      logic [31:0] inc = {lba[24:0], wi[6:0]};
      if (wi == 0) return lba[31:0];
      if (wi == 1) return {16'h0000, lba[47:32]};
      for (int k = 1; k < wi; k++) s = {s[30:0], s[30] ^ s[20] ^ s[0]};
      case (p)
         3'h0: return inc;
         3'h1: return ~inc;
         3'h3: return 32'hFFFF_FFFF;
         3'h4: return s;
         default: return 32'h0000_0000;
      endcase
   endfunction : exp_w
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      // no local limit: only the bench's hang guard may end this wait
      while (pready !== 1'b1)
         @(posedge core_clk);
      q = prdata;
      qerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_busy(input logic v);
      int n = 0;
      while (busy !== v && n < 5000)
      begin
         @(posedge core_clk);
         n++;
      end
   endtask : wait_busy
   // parameters stay untouched until the transfer ends
   task automatic prog(input logic [2:0] p, input logic [47:0] lba, input int len);
      apb(1'b1, `SPGC_OFF_LBA_LO, lba[31:0]);
      apb(1'b1, `SPGC_OFF_LBA_HI, {16'h0000, lba[47:32]});
      apb(1'b1, `SPGC_OFF_LEN, len);
      apb(1'b1, `SPGC_OFF_PAT, {29'h0, p});
   endtask : prog
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      apb(1'b0, `SPGC_OFF_LBA_LO, 32'h0);
      `CHK(q, `SPGC_LBA_RST & 32'hFFFF_FFFF)
      apb(1'b0, `SPGC_OFF_STATUS, 32'h0);
      `CHK(q, 32'h0000_0000)
      apb(1'b1, `SPGC_OFF_PAT, 32'h4);
      apb(1'b0, `SPGC_OFF_PAT, 32'h0);
      `CHK(q[2:0], 3'h4)
      apb(1'b0, `SPGC_OFF_CMD, 32'h0);
      `CHK(q, 32'h0000_0000)
      apb(1'b0, 8'h40, 32'h0);
      `CHK({qerr, q}, {1'b1, 32'h0})
      repeat (3) spgc_fifo_model_i.in_q.push_back(32'h0BAD_F00D);
      repeat (12) @(posedge core_clk);
      `CHK({spgc_fifo_model_i.in_q.size() == 0, fail}, 2'b10)
      apb(1'b1, `SPGC_OFF_LEN, 32'h0);
      apb(1'b1, `SPGC_OFF_CMD, 32'h1);
      repeat (4) @(posedge core_clk);
      `CHK(busy, 1'b0)
      $display("test regs done");
   endtask : t_regs
   task automatic t_wr(input logic [2:0] p, input logic [47:0] lba, input int len,
                       input logic st);
      stall <= st;
      prog(p, lba, len);
      // the stalled run sets both start bits; write must win over read
      apb(1'b1, `SPGC_OFF_CMD, st ? 32'h3 : 32'h1);
      wait_busy(1'b1);
      `CHK(busy, 1'b1)
      // a read start while busy must be dropped
      apb(1'b1, `SPGC_OFF_CMD, 32'h2);
      apb(1'b0, `SPGC_OFF_STATUS, 32'h0);
      `CHK(q[`SPGC_STS_RD_BIT:`SPGC_STS_WR_BIT], 2'b01)
      wait_busy(1'b0);
      repeat (3) @(posedge core_clk);
      `CHK(spgc_fifo_model_i.out_q.size(), len * 128)
      apb(1'b0, `SPGC_OFF_WCNT, 32'h0);
      `CHK(q, len * 128)
      for (int i = 0; i < len * 128 && i < spgc_fifo_model_i.out_q.size(); i++)
         `CHK(spgc_fifo_model_i.out_q[i], exp_w(lba + i / 128, i % 128, p))
      `CHK(ovf, 1'b0)
      spgc_fifo_model_i.out_q.delete();
      stall <= 1'b0;
      $display("test write pattern %0d done", p);
   endtask : t_wr
   task automatic t_rd(input logic [2:0] p, input logic [47:0] lba, input int len,
                       input int bad, input logic sl);
      logic [56:0] ba;
      slow <= sl;
      prog(p, lba, len);
      apb(1'b1, `SPGC_OFF_CMD, 32'h2);
      wait_busy(1'b1);
      for (int i = 0; i < len * 128; i++)
         spgc_fifo_model_i.in_q.push_back(exp_w(lba + i / 128, i % 128, p) ^
                                          ((i == bad) ? 32'h0000_0100 : 32'h0));
      wait_busy(1'b0);
      `CHK(fail, bad >= 0)
      apb(1'b0, `SPGC_OFF_STATUS, 32'h0);
      `CHK(q[`SPGC_STS_FAIL_BIT], bad >= 0)
      if (bad >= 0)
      begin
         w = exp_w(lba + bad / 128, bad % 128, p);
         ba = {lba + bad / 128, 7'(bad % 128), 2'b00};
         apb(1'b0, `SPGC_OFF_FAIL_LO, 32'h0);
         `CHK(q, ba[31:0])
         apb(1'b0, `SPGC_OFF_FAIL_HI, 32'h0);
         `CHK(q, {7'h00, ba[56:32]})
         apb(1'b0, `SPGC_OFF_EXP, 32'h0);
         `CHK(q, w)
         apb(1'b0, `SPGC_OFF_RCV, 32'h0);
         `CHK(q, w ^ 32'h0000_0100)
      end
      slow <= 1'b0;
      $display("test read pattern %0d done", p);
   endtask : t_rd
   // ****************************************
   // main sequence and verdict
   // ****************************************
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, stall, slow, drain, cyc} = '0;
      failures = 0;
      check_count = 0;
      rst = 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      t_regs();
      t_wr(3'h0, 48'h0012_FFFF_FFFF, 2, 1'b1);
      for (int p = 1; p < 6; p++)
         t_wr(3'(p), 48'h0000_8000_0001 + p, 1, 1'b0);
      t_rd(3'h4, 48'hABCD_DEAD_BEEF, 2, -1, 1'b1);
      t_rd(3'h0, 48'h0000_0000_0100, 1, 70, 1'b0);
      t_rd(3'h1, 48'h0000_0000_0200, 1, -1, 1'b0);
      wrap_up();
   end
endmodule : spgc_top_bench
